/* bench/asp_remote_model.sv */
// Remote transceiver model on the serial lines.
`timescale 1ns/1ps
module asp_remote_model (
  // Clock.
  input  wire logic clk_i,
  // Serial lines.
  input  wire logic tx_i,
  output logic      rx_o
);
  initial rx_o = 1'b1;
  task send(input int b, input logic [10:0] f, input int n);
    @(posedge clk_i);
    rx_o <= 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (b) @(posedge clk_i);
      rx_o <= f[i];
    end
    repeat (b) @(posedge clk_i);
    rx_o <= 1'b1;
  endtask
  task take(input int b, input int n, output logic [10:0] f, output int len);
    f = 11'h001;
    do @(negedge clk_i); while (tx_i);
    do @(negedge clk_i); while (!tx_i);
    len = 0;
    do begin
      @(negedge clk_i);
      len++;
    end while (tx_i);
    repeat (b / 2 - 1) @(negedge clk_i);
    for (int i = 1; i < n; i++) begin
      f[i] = tx_i;
      repeat (b) @(negedge clk_i);
    end
  endtask
endmodule

/* bench/asp_serial_port_properties.sv */
// Concurrent checks of the serial port handshakes, interrupt and transmit line.
`timescale 1ns/1ps
module asp_serial_port_properties (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus handshakes.
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Serial line and interrupt.
  input wire logic serial_tx_pin_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire aw_hs = s_axi_awvalid_i && s_axi_awready_o;
  wire w_hs  = s_axi_wvalid_i && s_axi_wready_o;
  property p_wans; aw_hs && w_hs |-> ##2 s_axi_bvalid_o; endproperty
  a_wans: assert property (p_wans) else $error("write answer late");
  property p_bdrop; s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o; endproperty
  a_bdrop: assert property (p_bdrop) else $error("write answer repeated");
  property p_rans; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_rdrop; s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o; endproperty
  a_rdrop: assert property (p_rdrop) else $error("read answer repeated");
  property p_arblk; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
  a_arblk: assert property (p_arblk) else $error("read taken while answering");
  property p_awblk; s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o; endproperty
  a_awblk: assert property (p_awblk) else $error("write taken while answering");
  property p_irqclr; $fell(irq_o) |-> $rose(s_axi_bvalid_o); endproperty
  a_irqclr: assert property (p_irqclr) else $error("flag cleared without write");
  property p_bitlen; $rose(serial_tx_pin_o) |=> $stable(serial_tx_pin_o) [*6]; endproperty
  a_bitlen: assert property (p_bitlen) else $error("transmit bit too short");
  c_write: cover property (aw_hs && w_hs);
  c_read: cover property (s_axi_rvalid_o && s_axi_rready_i);
  c_irq: cover property ($rose(irq_o));
endmodule

bind asp_serial_port asp_serial_port_properties chk (
  .clk_i, .rst_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
  .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
  .s_axi_rready_i, .serial_tx_pin_o, .irq_o);

/* bench/tb_async_serial_port_with_timer_baud.sv */
// Self-checking testbench of the serial port.
`timescale 1ns/1ps
`include "asp_defs.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_async_serial_port_with_timer_baud;
  typedef struct packed {logic [2:0] s; logic [7:0] d; logic m9; logic t8;} asp_txrow_t;
  typedef struct packed {logic [7:0] c; logic [10:0] f; logic [3:0] n; logic [2:0] ec;
    logic [7:0] ed;} asp_rxrow_t;
  localparam logic [7:0] RLD = 8'hF8;
  localparam logic [31:0] IDV = 32'h0000_A5C3;  // Arbitrary identification value.
  localparam int DIV [6] = '{1, 4, 12, 48, 4 * `ASP_DIV_EXT, 4};
  localparam asp_txrow_t TXR [6] = '{'{3'h0, 8'h35, 1'b0, 1'b0}, '{3'h1, 8'hC9, 1'b1, 1'b1},
    '{3'h2, 8'h5D, 1'b1, 1'b0}, '{3'h3, 8'hE1, 1'b0, 1'b0}, '{3'h4, 8'h01, 1'b1, 1'b1},
    '{3'h5, 8'hFD, 1'b0, 1'b0}};
  localparam asp_rxrow_t RXR [6] = '{'{8'h10, 11'h13C, 4'h9, 3'h5, 8'h3C},
    '{8'h11, 11'h1A7, 4'h9, 3'h1, 8'h3C}, '{8'h00, 11'h155, 4'h9, 3'h0, 8'h3C},
    '{8'h30, 11'h055, 4'h9, 3'h0, 8'h3C}, '{8'hB0, 11'h266, 4'hA, 3'h0, 8'h3C},
    '{8'hB0, 11'h199, 4'hA, 3'h5, 8'h99}};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [31:0] awa = '0, wd = '0, ara = '0, rdv;
  logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [1:0]  pc = 2'h0, br_q, rr_q;
  logic [10:0] f;
  wire         awr, wrd, bv, arr, rv, tx, rx, irq_o;
  wire [1:0]   bre, rre;
  wire [31:0]  rdt;
  wire         baud_timer_ext_input_i = pc[1];
  wire         ext_osc_i = pc[1];
  int          errors = 0, check_count = 0, cyc = 0, len, b;
  asp_serial_port #(.ID_VALUE(IDV)) dut (.clk_i, .rst_i, .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrd), .s_axi_bresp_o(bre), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdt),
    .s_axi_rresp_o(rre), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .ext_osc_i,
    .baud_timer_ext_input_i, .serial_rx_pin_i(rx), .serial_tx_pin_o(tx), .irq_o);
  asp_remote_model peer (.clk_i, .tx_i(tx), .rx_o(rx));
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    pc <= pc + 2'h1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      end_of_test();
    end
  end
  task end_of_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    awa <= {24'h00_0000, a};
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(negedge clk_i);
      aw = awv && awr;
      w = wv && wrd;
      @(posedge clk_i);
      if (aw) awv <= 1'b0;
      if (w) wv <= 1'b0;
    end while ((awv && !aw) || (wv && !w));
    do @(negedge clk_i); while (!bv);
    br_q = bre;
    @(posedge clk_i);
    bry <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    ara <= {24'h00_0000, a};
    arv <= 1'b1;
    rry <= 1'b1;
    do @(negedge clk_i); while (!arr);
    @(posedge clk_i);
    arv <= 1'b0;
    do @(negedge clk_i); while (!rv);
    d = rdt;
    rr_q = rre;
    @(posedge clk_i);
    rry <= 1'b0;
    @(posedge clk_i);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK("tx idle", 1'b1, tx)
    `CHK("irq idle", 1'b0, irq_o)
    rd_reg(`ASP_CTRL_OFS, rdv);
    `CHK("ctrl reset", 8'h40, rdv[7:0])
    `CHK("read resp", 2'h0, rr_q)
    $display("reset test done");
    foreach (TXR[k]) begin
      b = 16 * DIV[TXR[k].s];
      wr_reg(`ASP_BAUD_OFS, {20'h0_0000, TXR[k].s, 1'b1, RLD});
      wr_reg(`ASP_CTRL_OFS, {24'h00_0000, TXR[k].m9, 3'h0, TXR[k].t8, 3'h0});
      fork
        peer.take(b, TXR[k].m9 ? 10 : 9, f, len);
        wr_reg(`ASP_DATA_OFS, {24'h00_0000, TXR[k].d});
      join
      `CHK("bit time", b, len)
      `CHK("frame", TXR[k].m9 ? {2'h1, TXR[k].t8, TXR[k].d} : {3'h1, TXR[k].d}, f)
      rd_reg(`ASP_CTRL_OFS, rdv);
      `CHK("tx done", 1'b1, rdv[`ASP_F_TI])
      `CHK("irq set", 1'b1, irq_o)
      wr_reg(`ASP_CTRL_OFS, {24'h00_0000, TXR[k].m9, 7'h00});
      `CHK("irq clear", 1'b0, irq_o)
      $display("tx row %0d done", k);
    end
    wr_reg(`ASP_BAUD_OFS, {20'h0_0000, 3'h0, 1'b1, RLD});
    foreach (RXR[k]) begin
      wr_reg(`ASP_CTRL_OFS, {24'h00_0000, RXR[k].c});
      peer.send(16, RXR[k].f, RXR[k].n);
      repeat (16) @(posedge clk_i);
      rd_reg(`ASP_CTRL_OFS, rdv);
      `CHK("rx flags", RXR[k].ec, rdv[2:0])
      rd_reg(`ASP_DATA_OFS, rdv);
      `CHK("rx data", RXR[k].ed, rdv[7:0])
      $display("rx row %0d done", k);
    end
    wr_reg(`ASP_DATA_OFS, 32'h0000_0042);
    rd_reg(`ASP_DATA_OFS, rdv);
    `CHK("data read", 8'h99, rdv[7:0])
    wr_reg(8'h10, 32'h0000_0000);
    `CHK("bad write", 2'h2, br_q)
    rd_reg(8'h10, rdv);
    `CHK("bad read", 32'h0000_0000, rdv)
    `CHK("bad read resp", 2'h2, rr_q)
    rd_reg(`ASP_BAUD_OFS, rdv);
    `CHK("baud read", {20'h0_0000, 3'h0, 1'b1, RLD}, rdv)
    rd_reg(`ASP_ID_OFS, rdv);
    `CHK("id read", IDV, rdv)
    $display("edge tests done");
    end_of_test();
  end
endmodule

/* src/asp_defs.svh */
// Register offsets, field positions, reset values and timing constants of the serial port.
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH
`define ASP_CTRL_OFS     8'h00
`define ASP_DATA_OFS     8'h04
`define ASP_BAUD_OFS     8'h08
`define ASP_ID_OFS       8'h0C
`define ASP_CTRL_RST     8'h40
`define ASP_BAUD_RST     16'h0000
`define ASP_F_MODE       7
`define ASP_F_UNUSED     6
`define ASP_F_MCE        5
`define ASP_F_REN        4
`define ASP_F_TB8        3
`define ASP_F_RB8        2
`define ASP_F_TI         1
`define ASP_F_RI         0
`define ASP_B_RUN        8
`define ASP_B_SRC_LO     9
`define ASP_B_SRC_HI     11
`define ASP_DIV_EXT      8
`endif

/* src/asp_pkg.sv */
// Types of the serial port.
package asp_pkg;
  typedef enum logic [2:0] {
    ASP_SRC_CLK1  = 3'h0,
    ASP_SRC_CLK4  = 3'h1,
    ASP_SRC_CLK12 = 3'h2,
    ASP_SRC_CLK48 = 3'h3,
    ASP_SRC_EXT8  = 3'h4,
    ASP_SRC_PIN   = 3'h5
  } asp_src_t;
  typedef enum logic [2:0] {
    ASP_IDLE  = 3'b001,
    ASP_SHIFT = 3'b010,
    ASP_STOP  = 3'b100
  } asp_phase_t;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  rx_buf;
    logic [7:0]  reload;
    logic        run;
    logic [2:0]  src;
    logic [5:0]  pre;
    logic [2:0]  ext_sync;
    logic [2:0]  pin_sync;
    logic [2:0]  rx_sync;
    logic        ext_lvl;
    logic        pin_lvl;
    logic        rx_lvl;
    logic [7:0]  tx_tmr;
    logic [7:0]  rx_tmr;
    logic        tx_half;
    logic        rx_half;
    asp_phase_t  tx_ph;
    logic [9:0]  tx_sh;
    logic [3:0]  tx_cnt;
    logic        tx_line;
    asp_phase_t  rx_ph;
    logic [8:0]  rx_sh;
    logic [3:0]  rx_cnt;
    logic        aw_ok;
    logic [7:0]  aw_a;
    logic        w_ok;
    logic [31:0] w_d;
    logic [3:0]  w_s;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } asp_state_t;
endpackage

/* src/asp_serial_port.sv */
// Full-duplex asynchronous serial port with timer baud generator and AXI4-Lite registers.
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "asp_defs.svh"

module asp_serial_port #(
  parameter logic [31:0] ID_VALUE = 32'h0000_5A5A  // Arbitrary identification value.
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // AXI4-Lite write address and data.
  input  wire logic [31:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output      logic        s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output      logic        s_axi_wready_o,
  // AXI4-Lite write response.
  output      logic [1:0]  s_axi_bresp_o,
  output      logic        s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // AXI4-Lite read.
  input  wire logic [31:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output      logic        s_axi_arready_o,
  output      logic [31:0] s_axi_rdata_o,
  output      logic [1:0]  s_axi_rresp_o,
  output      logic        s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Clock sources and serial pins.
  input  wire logic        ext_osc_i,
  input  wire logic        baud_timer_ext_input_i,
  input  wire logic        serial_rx_pin_i,
  output      logic        serial_tx_pin_o,
  // Interrupt request.
  output      logic        irq_o
);

  asp_pkg::asp_state_t s;
  asp_pkg::asp_state_t next_s;

  logic        wr_go;
  logic        rd_go;
  logic        tick;
  logic        ext_rise;
  logic        tx_ovf;
  logic        rx_ovf;
  logic        tx_bit;
  logic        rx_bit;
  logic        rx_start;
  logic        frame9;
  logic        do_load;
  logic [7:0]  ctrl_wr;
  logic [31:0] rd_val;
  logic        rd_bad;

  //////////////////////////////////////////////////////////////////////////////
  // Handshake outputs.
  assign s_axi_awready_o = !s.aw_ok && !s.bvalid;
  assign s_axi_wready_o  = !s.w_ok && !s.bvalid;
  assign s_axi_arready_o = !s.rvalid;
  assign s_axi_bvalid_o  = s.bvalid;
  assign s_axi_bresp_o   = s.bresp;
  assign s_axi_rvalid_o  = s.rvalid;
  assign s_axi_rdata_o   = s.rdata;
  assign s_axi_rresp_o   = s.rresp;
  assign serial_tx_pin_o = s.tx_line;
  assign irq_o = s.ctrl[`ASP_F_TI] | s.ctrl[`ASP_F_RI];

  assign wr_go  = s.aw_ok && s.w_ok && !s.bvalid;
  assign rd_go  = s_axi_arvalid_i && !s.rvalid;
  assign frame9 = s.ctrl[`ASP_F_MODE];
  assign ext_rise = (s.ext_sync[2] == s.ext_sync[1]) && s.ext_sync[2] && !s.ext_lvl;

  //////////////////////////////////////////////////////////////////////////////
  // Read decode.
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_bad = 1'b0;
    unique case (s_axi_araddr_i[7:0])
      `ASP_CTRL_OFS: rd_val = {24'h00_0000, s.ctrl};
      `ASP_DATA_OFS: rd_val = {24'h00_0000, s.rx_buf};
      `ASP_BAUD_OFS: rd_val = {20'h0_0000, s.src, s.run, s.reload};
      `ASP_ID_OFS:   rd_val = ID_VALUE;
      default:       rd_bad = 1'b1;
    endcase
  end

  // Timer clock selection from a free prescaler and synchronised pins.
  always_comb begin
    unique case (asp_pkg::asp_src_t'(s.src))
      asp_pkg::ASP_SRC_CLK1:  tick = 1'b1;
      asp_pkg::ASP_SRC_CLK4:  tick = (s.pre[1:0] == 2'h3);
      asp_pkg::ASP_SRC_CLK12: tick = (s.pre % 6'd12 == 6'd11);
      asp_pkg::ASP_SRC_CLK48: tick = (s.pre == 6'd47);
      asp_pkg::ASP_SRC_EXT8:  tick = ext_rise && (s.pre[2:0] == 3'(`ASP_DIV_EXT - 1));
      asp_pkg::ASP_SRC_PIN:   tick = (s.pin_sync[2] == s.pin_sync[1]) && s.pin_sync[2]
                                     && !s.pin_lvl;
      default:                tick = 1'b0;
    endcase
  end

  assign tx_ovf   = s.run && tick && (s.tx_tmr == 8'hFF);
  assign rx_ovf   = s.run && tick && (s.rx_tmr == 8'hFF);
  assign tx_bit   = tx_ovf && s.tx_half;
  assign rx_bit   = rx_ovf && s.rx_half;
  assign rx_start = (s.rx_ph == asp_pkg::ASP_IDLE) && s.ctrl[`ASP_F_REN]
                    && !s.rx_lvl && (s.rx_sync[2] == s.rx_sync[1]);

  // Load only into an empty buffer and past the multidrop filter.
  assign do_load = !s.ctrl[`ASP_F_RI]
                   && (!s.ctrl[`ASP_F_MCE] || s.rx_sh[8]);

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    next_s = s;
    ctrl_wr = s.ctrl;
    // Input synchronisers.
    next_s.ext_sync = {s.ext_sync[1:0], ext_osc_i};
    next_s.pin_sync = {s.pin_sync[1:0], baud_timer_ext_input_i};
    next_s.rx_sync  = {s.rx_sync[1:0], serial_rx_pin_i};
    if (s.ext_sync[2] == s.ext_sync[1]) begin
      next_s.ext_lvl = s.ext_sync[2];
    end
    if (s.pin_sync[2] == s.pin_sync[1]) begin
      next_s.pin_lvl = s.pin_sync[2];
    end
    if (s.rx_sync[2] == s.rx_sync[1]) begin
      next_s.rx_lvl = s.rx_sync[2];
    end
    // Prescaler; the external oscillator divides by eight.
    next_s.pre = (s.pre == 6'd47) ? 6'd0 : s.pre + 6'd1;
    if (asp_pkg::asp_src_t'(s.src) == asp_pkg::ASP_SRC_EXT8) begin
      next_s.pre = {3'h0, s.pre[2:0] + {2'h0, ext_rise}};
    end
    // Baud timers, auto-reload from the shared reload value.
    if (s.run && tick) begin
      next_s.tx_tmr = tx_ovf ? s.reload : s.tx_tmr + 8'd1;
      next_s.rx_tmr = rx_ovf ? s.reload : s.rx_tmr + 8'd1;
    end
    if (tx_ovf) begin
      next_s.tx_half = !s.tx_half;
    end
    if (rx_ovf) begin
      next_s.rx_half = !s.rx_half;
    end
    // Bus write channels and read response.
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      next_s.aw_ok = 1'b1;
      next_s.aw_a  = s_axi_awaddr_i[7:0];
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      next_s.w_ok = 1'b1;
      next_s.w_d  = s_axi_wdata_i;
      next_s.w_s  = s_axi_wstrb_i;
    end
    if (s.bvalid && s_axi_bready_i) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && s_axi_rready_i) begin
      next_s.rvalid = 1'b0;
    end
    if (rd_go) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd_val;
      next_s.rresp  = rd_bad ? 2'b10 : 2'b00;
    end
    if (wr_go) begin
      next_s.aw_ok  = 1'b0;
      next_s.w_ok   = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = 2'b00;
      if (s.w_s[0]) begin
        unique case (s.aw_a)
          `ASP_CTRL_OFS: ctrl_wr = {s.w_d[7], 1'b1, s.w_d[5:0]};
          `ASP_DATA_OFS: begin
            next_s.tx_sh  = {1'b1, s.w_d[7:0], 1'b0};
            next_s.tx_cnt = frame9 ? 4'd10 : 4'd9;
            next_s.tx_ph  = asp_pkg::ASP_SHIFT;
            next_s.tx_line = 1'b0;
            next_s.tx_half = 1'b0;
          end
          `ASP_BAUD_OFS: next_s.reload = s.w_d[7:0];
          `ASP_ID_OFS:   ctrl_wr = s.ctrl;
          default:       next_s.bresp = 2'b10;
        endcase
        if (s.aw_a == `ASP_BAUD_OFS && s.w_s[1]) begin
          next_s.run = s.w_d[`ASP_B_RUN];
          next_s.src = s.w_d[`ASP_B_SRC_HI:`ASP_B_SRC_LO];
        end
      end
    end
    next_s.ctrl = ctrl_wr;
    // Transmitter: ninth bit inserted before the stop bit.
    unique case (s.tx_ph)
      asp_pkg::ASP_IDLE: next_s.tx_line = (next_s.tx_ph == asp_pkg::ASP_SHIFT) ? 1'b0 : 1'b1;
      asp_pkg::ASP_SHIFT: begin
        if (tx_bit) begin
          next_s.tx_cnt = s.tx_cnt - 4'd1;
          if (frame9 && s.tx_cnt == 4'd2) begin
            next_s.tx_line = s.ctrl[`ASP_F_TB8];
          end else if (s.tx_cnt == 4'd1) begin
            next_s.tx_line = 1'b1;
            next_s.tx_ph   = asp_pkg::ASP_STOP;
            next_s.ctrl[`ASP_F_TI] = 1'b1;
          end else begin
            next_s.tx_line = s.tx_sh[1];
            next_s.tx_sh   = {1'b1, s.tx_sh[9:1]};
          end
        end
      end
      asp_pkg::ASP_STOP: begin
        next_s.tx_line = 1'b1;
        if (tx_bit) begin
          next_s.tx_ph = asp_pkg::ASP_IDLE;
        end
      end
      default: next_s.tx_ph = asp_pkg::ASP_IDLE;
    endcase
    // Receiver, sampling at the middle of each bit.
    unique case (s.rx_ph)
      asp_pkg::ASP_IDLE: begin
        if (rx_start) begin
          next_s.rx_tmr  = s.reload;
          next_s.rx_half = 1'b0;
          next_s.rx_cnt  = frame9 ? 4'd11 : 4'd10;
          next_s.rx_ph   = asp_pkg::ASP_SHIFT;
        end
      end
      asp_pkg::ASP_SHIFT: begin
        if (rx_ovf && !s.rx_half) begin
          next_s.rx_cnt = s.rx_cnt - 4'd1;
          if ((s.rx_cnt == (frame9 ? 4'd11 : 4'd10)) && s.rx_lvl) begin
            next_s.rx_ph = asp_pkg::ASP_IDLE;
          end else if (s.rx_cnt == 4'd1) begin
            next_s.rx_ph = asp_pkg::ASP_STOP;
            if (!frame9) begin
              next_s.rx_sh = {s.rx_lvl, s.rx_sh[7:0]};
            end
          end else if (s.rx_cnt != (frame9 ? 4'd11 : 4'd10)) begin
            next_s.rx_sh = frame9 ? {s.rx_lvl, s.rx_sh[8:1]}
                                  : {1'b0, s.rx_lvl, s.rx_sh[7:1]};
          end
        end
      end
      asp_pkg::ASP_STOP: begin
        next_s.rx_ph = asp_pkg::ASP_IDLE;
        if (do_load) begin
          next_s.rx_buf = s.rx_sh[7:0];
          next_s.ctrl[`ASP_F_RB8] = s.rx_sh[8];
          next_s.ctrl[`ASP_F_RI]  = 1'b1;
        end
      end
      default: next_s.rx_ph = asp_pkg::ASP_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s          <= '0;
      s.ctrl     <= `ASP_CTRL_RST;
      s.tx_ph    <= asp_pkg::ASP_IDLE;
      s.rx_ph    <= asp_pkg::ASP_IDLE;
      s.tx_line  <= 1'b1;
      s.rx_lvl   <= 1'b1;
      s.rx_sync  <= 3'h7;
    end else begin
      s <= next_s;
    end
  end

endmodule
